// File: core/acr_pkg.sv
// shared constants for the converter control block
package acr_pkg;
   // register offsets
   localparam logic [2:0] ACR_OFF_INPUT_SELECT = 3'h0;
   localparam logic [2:0] ACR_OFF_CTRL_STATUS  = 3'h1;
   localparam logic [2:0] ACR_OFF_RESULT_LOW   = 3'h2;
   localparam logic [2:0] ACR_OFF_RESULT_HIGH  = 3'h3;
   localparam logic [2:0] ACR_OFF_SPECIAL_FUNC = 3'h4;
   localparam logic [2:0] ACR_OFF_CPU_STATUS   = 3'h5;
   // control and status field positions
   localparam int ACR_BIT_ENABLE    = 7;
   localparam int ACR_BIT_START     = 6;
   localparam int ACR_BIT_FREE_RUN  = 5;
   localparam int ACR_BIT_DONE      = 4;
   localparam int ACR_BIT_IRQ_EN    = 3;
   // input select, special function and cpu status field positions
   localparam int ACR_BIT_LEFT_ADJ  = 5;
   localparam int ACR_BIT_HIGH_SPD  = 4;
   localparam int ACR_BIT_GLOBAL_IE = 7;
   // reset values
   localparam logic [7:0] ACR_RESET_BYTE = 8'h00;
   // conversion lengths in converter clock cycles
   localparam logic [4:0] ACR_FIRST_CYCLES  = 5'h19;
   localparam logic [4:0] ACR_NORMAL_CYCLES = 5'h0D;
   // prescaler: divide codes 000 and 001 both by two
   localparam logic [2:0] ACR_MIN_DIV_CODE = 3'h1;
   // channel code boundaries
   localparam logic [4:0] ACR_CH_LAST_SINGLE = 5'h07;
   localparam logic [4:0] ACR_CH_FIRST_UNITY = 5'h10;
   localparam logic [4:0] ACR_CH_BANDGAP     = 5'h1E;
   localparam logic [4:0] ACR_CH_GROUND      = 5'h1F;
   // gain codes
   localparam logic [1:0] ACR_GAIN_1X   = 2'h0;
   localparam logic [1:0] ACR_GAIN_10X  = 2'h1;
   localparam logic [1:0] ACR_GAIN_200X = 2'h2;
   // source kinds driven to the analog core
   typedef enum logic [1:0] {
      ACR_SRC_SINGLE  = 2'h0,
      ACR_SRC_DIFF    = 2'h1,
      ACR_SRC_BANDGAP = 2'h2,
      ACR_SRC_GROUND  = 2'h3
   } acr_src_t;
   typedef enum logic [2:0] {
      ACR_ST_IDLE = 3'b001,
      ACR_ST_CONV = 3'b010,
      ACR_ST_DONE = 3'b100
   } acr_state_t;
endpackage : acr_pkg

// File: core/acr_core_if.sv
// link between the sequencer and the analog core model
interface acr_core_if;
   import acr_pkg::*;
   logic       start;
   logic       tick;
   logic [4:0] cycles;
   logic [2:0] pos_ch;
   logic [2:0] neg_ch;
   acr_src_t   src;
   logic [1:0] gain;
   logic [1:0] ref_sel;
   logic       high_speed;
   logic       ready;
   logic [9:0] sample;
   modport ctrl (output start, tick, cycles, pos_ch, neg_ch, src, gain, ref_sel, high_speed,
                 input ready, sample);
   modport core (input start, tick, cycles, pos_ch, neg_ch, src, gain, ref_sel, high_speed,
                 output ready, sample);
endinterface : acr_core_if

// File: core/acr_prescaler.sv
// converter clock enable divider
module acr_prescaler
   import acr_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // control
   input  wire logic       run,
   input  wire logic [2:0] div_sel,
   // converter clock enable
   output      logic       tick
);
   logic [6:0] cnt_q, cnt_d;
   logic [6:0] limit;
   logic       tick_d;
   always_comb begin
      // codes 000 and 001 both give divide by two
      if (div_sel <= ACR_MIN_DIV_CODE) begin
         limit = 7'h01;
      end else begin
         limit = 7'((8'h01 << div_sel) - 8'h01);
      end
      tick_d = 1'b0;
      cnt_d  = cnt_q;
      if (!run) begin
         cnt_d = 7'h00;
      end else if (cnt_q >= limit) begin
         cnt_d  = 7'h00;
         tick_d = 1'b1;
      end else begin
         cnt_d = cnt_q + 7'h01;
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 7'h00;
         tick  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick  <= tick_d;
      end
   end
endmodule : acr_prescaler

// File: core/acr_analog_core.sv
// digital stand-in for the successive approximation core
module acr_analog_core
   import acr_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // sample value presented by the analog front end
   input  wire logic [9:0] analog_value,
   // sequencer link
   acr_core_if.core        cif
);
   logic [4:0] left_q, left_d;
   logic       busy_q, busy_d;
   logic       ready_q, ready_d;
   logic [9:0] smp_q, smp_d;
   always_comb begin
      left_d  = left_q;
      busy_d  = busy_q;
      ready_d = 1'b0;
      smp_d   = smp_q;
      if (cif.start) begin
         left_d = cif.cycles;
         busy_d = 1'b1;
      end else if (busy_q && cif.tick) begin
         if (left_q == 5'h01) begin
            busy_d  = 1'b0;
            ready_d = 1'b1;
            if (cif.src == ACR_SRC_GROUND) begin
               smp_d = 10'h000;
            end else begin
               smp_d = analog_value;
            end
         end
         left_d = left_q - 5'h01;
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         left_q  <= 5'h00;
         busy_q  <= 1'b0;
         ready_q <= 1'b0;
         smp_q   <= 10'h000;
      end else begin
         left_q  <= left_d;
         busy_q  <= busy_d;
         ready_q <= ready_d;
         smp_q   <= smp_d;
      end
   end
   assign cif.ready  = ready_q;
   assign cif.sample = smp_q;
endmodule : acr_analog_core

// File: core/acr_top.sv
// converter control, channel selection and result registers
//
// Added by the designer: the register offsets and the address-and-strobe port.
module acr_top
   import acr_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // register port
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output      logic [7:0] reg_rdata,
   // interrupt handshake with the processor
   input  wire logic       irq_ack,
   output      logic       irq_req,
   // analog front end
   input  wire logic [9:0] analog_value,
   output      logic       conv_powered,
   output      logic [2:0] pos_channel,
   output      logic [2:0] neg_channel,
   output      logic [1:0] gain_select,
   output      logic [1:0] reference_select_out
);
   import acr_pkg::*;

   acr_core_if cif ();

   // software registers
   logic [7:0] input_select_q, input_select_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic       high_speed_select_q, high_speed_select_d;
   logic       cpu_ie_q, cpu_ie_d;
   // state
   acr_state_t st_q, st_d;
   logic       first_q, first_d;
   logic [9:0] result_q, result_d;
   logic       lock_q, lock_d;
   logic [4:0] act_sel_q, act_sel_d;
   logic [1:0] act_ref_q, act_ref_d;
   logic [7:0] rdata_d;
   logic       start_d;
   logic       irq_d;
   logic [7:0] res_low, res_high;
   logic       wr_ctrl;
   logic       tick;

   assign wr_ctrl = reg_wr && (reg_addr == ACR_OFF_CTRL_STATUS);

   acr_prescaler u_presc (
      .ref_clk (ref_clk),
      .rst     (rst),
      .run     (ctrl_q[ACR_BIT_ENABLE]),
      .div_sel (ctrl_q[2:0]),
      .tick    (tick)
   );

   acr_analog_core u_core (
      .ref_clk      (ref_clk),
      .rst          (rst),
      .analog_value (analog_value),
      .cif          (cif.core)
   );

   // result formatting follows the live left adjust bit
   always_comb begin
      if (input_select_q[ACR_BIT_LEFT_ADJ]) begin
         res_high = result_q[9:2];
         res_low  = {result_q[1:0], 6'h00};
      end else begin
         res_high = {6'h00, result_q[9:8]};
         res_low  = result_q[7:0];
      end
   end

   // channel decode from the selection being converted
   always_comb begin
      cif.src    = ACR_SRC_DIFF;
      cif.gain   = ACR_GAIN_1X;
      cif.pos_ch = 3'h0;
      cif.neg_ch = 3'h0;
      if (act_sel_q <= ACR_CH_LAST_SINGLE) begin
         cif.src    = ACR_SRC_SINGLE;
         cif.pos_ch = act_sel_q[2:0];
      end else if (act_sel_q == ACR_CH_BANDGAP) begin
         cif.src = ACR_SRC_BANDGAP;
      end else if (act_sel_q == ACR_CH_GROUND) begin
         cif.src = ACR_SRC_GROUND;
      end else if (act_sel_q < ACR_CH_FIRST_UNITY) begin
         // 01xxx: bit2 picks the input pair 0/1 vs 2/3, bit1 the gain
         cif.pos_ch = {1'b0, act_sel_q[2], act_sel_q[0]};
         cif.neg_ch = {1'b0, act_sel_q[2], 1'b0};
         cif.gain   = act_sel_q[1] ? ACR_GAIN_200X : ACR_GAIN_10X;
      end else begin
         // 10xxx against input 1, 11xxx against input 2, unity gain
         cif.pos_ch = act_sel_q[2:0];
         cif.neg_ch = act_sel_q[3] ? 3'h2 : 3'h1;
      end
   end

   assign cif.tick       = tick;
   assign cif.ref_sel    = act_ref_q;
   assign cif.high_speed = high_speed_select_q;

   // register writes and the conversion sequence
   always_comb begin
      input_select_d      = input_select_q;
      ctrl_d              = ctrl_q;
      high_speed_select_d = high_speed_select_q;
      cpu_ie_d            = cpu_ie_q;
      st_d                = st_q;
      first_d             = first_q;
      result_d            = result_q;
      lock_d              = lock_q;
      act_sel_d           = act_sel_q;
      act_ref_d           = act_ref_q;
      start_d             = 1'b0;
      if (reg_wr) begin
         if (reg_addr == ACR_OFF_INPUT_SELECT) begin
            input_select_d = reg_wdata;
         end else if (reg_addr == ACR_OFF_CTRL_STATUS) begin
            ctrl_d[ACR_BIT_ENABLE]   = reg_wdata[ACR_BIT_ENABLE];
            ctrl_d[ACR_BIT_FREE_RUN] = reg_wdata[ACR_BIT_FREE_RUN];
            ctrl_d[ACR_BIT_IRQ_EN]   = reg_wdata[ACR_BIT_IRQ_EN];
            ctrl_d[2:0]              = reg_wdata[2:0];
            if (reg_wdata[ACR_BIT_DONE]) begin
               ctrl_d[ACR_BIT_DONE] = 1'b0;
            end
         end else if (reg_addr == ACR_OFF_SPECIAL_FUNC) begin
            high_speed_select_d = reg_wdata[ACR_BIT_HIGH_SPD];
         end else if (reg_addr == ACR_OFF_CPU_STATUS) begin
            cpu_ie_d = reg_wdata[ACR_BIT_GLOBAL_IE];
         end
      end
      if (irq_ack) begin
         ctrl_d[ACR_BIT_DONE] = 1'b0;
      end
      // reading the low byte locks; reading the high byte releases
      if (reg_rd && reg_addr == ACR_OFF_RESULT_LOW) begin
         lock_d = 1'b1;
      end else if (reg_rd && reg_addr == ACR_OFF_RESULT_HIGH) begin
         lock_d = 1'b0;
      end
      // the long length is used up once the core has taken its start pulse
      if (cif.start) begin
         first_d = 1'b0;
      end
      // enabling rearms the long initialisation conversion
      if (wr_ctrl && reg_wdata[ACR_BIT_ENABLE] && !ctrl_q[ACR_BIT_ENABLE]) begin
         first_d = 1'b1;
      end
      case (st_q)
         ACR_ST_IDLE: begin
            // nothing converts here, so a new selection applies at once
            act_sel_d = input_select_d[4:0];
            act_ref_d = input_select_d[7:6];
            // start written as zero is simply ignored
            if (wr_ctrl && reg_wdata[ACR_BIT_START] && reg_wdata[ACR_BIT_ENABLE]) begin
               st_d      = ACR_ST_CONV;
               start_d   = 1'b1;
               act_sel_d = input_select_d[4:0];
               act_ref_d = input_select_d[7:6];
            end
         end
         ACR_ST_CONV: begin
            if (!ctrl_d[ACR_BIT_ENABLE]) begin
               st_d = ACR_ST_IDLE;
            end else if (cif.ready && !cif.start) begin
               // a late ready left over from an aborted run must not end a fresh one
               // result and flag move together; held result if low byte locked
               if (!lock_d) begin
                  result_d = cif.sample;
               end
               ctrl_d[ACR_BIT_DONE] = 1'b1;
               act_sel_d = input_select_d[4:0];
               act_ref_d = input_select_d[7:6];
               st_d      = ACR_ST_DONE;
            end
         end
         ACR_ST_DONE: begin
            act_sel_d = input_select_d[4:0];
            act_ref_d = input_select_d[7:6];
            if (ctrl_d[ACR_BIT_ENABLE] && ctrl_d[ACR_BIT_FREE_RUN]) begin
               st_d    = ACR_ST_CONV;
               start_d = 1'b1;
            end else begin
               st_d = ACR_ST_IDLE;
            end
         end
         default: begin
            st_d = ACR_ST_IDLE;
         end
      endcase
      ctrl_d[ACR_BIT_START] = (st_d != ACR_ST_IDLE);
   end

   // launch length picks the long first conversion when armed
   assign cif.cycles = first_q ? ACR_FIRST_CYCLES : ACR_NORMAL_CYCLES;

   always_comb begin
      rdata_d = ACR_RESET_BYTE;
      if (reg_rd) begin
         if (reg_addr == ACR_OFF_INPUT_SELECT) begin
            rdata_d = input_select_q;
         end else if (reg_addr == ACR_OFF_CTRL_STATUS) begin
            rdata_d = ctrl_q;
         end else if (reg_addr == ACR_OFF_RESULT_LOW) begin
            rdata_d = res_low;
         end else if (reg_addr == ACR_OFF_RESULT_HIGH) begin
            rdata_d = res_high;
         end else if (reg_addr == ACR_OFF_SPECIAL_FUNC) begin
            rdata_d = {3'h0, high_speed_select_q, 4'h0};
         end else if (reg_addr == ACR_OFF_CPU_STATUS) begin
            rdata_d = {cpu_ie_q, 7'h00};
         end
      end
      irq_d = ctrl_d[ACR_BIT_DONE] && ctrl_d[ACR_BIT_IRQ_EN] && cpu_ie_d;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         input_select_q      <= ACR_RESET_BYTE;
         ctrl_q              <= ACR_RESET_BYTE;
         high_speed_select_q <= 1'b0;
         cpu_ie_q            <= 1'b0;
         st_q                <= ACR_ST_IDLE;
         first_q             <= 1'b1;
         result_q            <= 10'h000;
         lock_q              <= 1'b0;
         act_sel_q           <= 5'h00;
         act_ref_q           <= 2'h0;
         cif.start           <= 1'b0;
         reg_rdata           <= ACR_RESET_BYTE;
         irq_req             <= 1'b0;
         conv_powered        <= 1'b0;
         pos_channel         <= 3'h0;
         neg_channel         <= 3'h0;
         gain_select         <= 2'h0;
         reference_select_out <= 2'h0;
      end else begin
         input_select_q      <= input_select_d;
         ctrl_q              <= ctrl_d;
         high_speed_select_q <= high_speed_select_d;
         cpu_ie_q            <= cpu_ie_d;
         st_q                <= st_d;
         first_q             <= first_d;
         result_q            <= result_d;
         lock_q              <= lock_d;
         act_sel_q           <= act_sel_d;
         act_ref_q           <= act_ref_d;
         cif.start           <= start_d;
         reg_rdata           <= rdata_d;
         irq_req             <= irq_d;
         conv_powered        <= ctrl_d[ACR_BIT_ENABLE];
         pos_channel         <= cif.pos_ch;
         neg_channel         <= cif.neg_ch;
         gain_select         <= cif.gain;
         reference_select_out <= act_ref_q;
      end
   end
endmodule : acr_top

// File: test/acr_front_model.sv
// stand-in for the analog front end that feeds sample values
module acr_front_model (
   // front end control
   input  wire logic       conv_powered,
   input  wire logic [9:0] level,
   // sample value
   output      logic [9:0] analog_value
);
   timeunit 1ns;
   timeprecision 1ps;
   // unpowered front end shows the inverse so a stale sample never matches
   assign analog_value = conv_powered ? level : ~level;
endmodule : acr_front_model

// File: test/acr_top_chk.sv
// port-level property checker for the converter control block
module acr_top_chk
   import acr_pkg::*;
(
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       rst,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   // interrupt
   input wire logic       irq_ack,
   input wire logic       irq_req,
   // front end
   input wire logic       conv_powered,
   input wire logic [2:0] pos_channel,
   input wire logic [2:0] neg_channel,
   input wire logic [1:0] gain_select,
   input wire logic [1:0] reference_select_out
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic ctl_wr;
   logic sel_wr;
   assign ctl_wr = reg_wr && reg_addr == ACR_OFF_CTRL_STATUS;
   // only unpowered writes: while converting the selection is held back
   assign sel_wr = reg_wr && reg_addr == ACR_OFF_INPUT_SELECT && !conv_powered;

   AST_POWER_ON: assert property (ctl_wr && reg_wdata[7] |-> ##[1:2] conv_powered)
      else $error("converter not powered after enable write");
   AST_POWER_OFF: assert property (ctl_wr && !reg_wdata[7] |-> ##[1:2] !conv_powered)
      else $error("converter still powered after disable write");
   AST_SEL_SINGLE: assert property (sel_wr && reg_wdata[4:0] == 5'h06 |-> ##[1:3] pos_channel == 3'h6 && gain_select == ACR_GAIN_1X)
      else $error("single-ended code 6 decoded wrongly");
   AST_SEL_200X: assert property (sel_wr && reg_wdata[4:0] == 5'h0B |-> ##[1:3] pos_channel == 3'h1 && neg_channel == 3'h0 && gain_select == ACR_GAIN_200X)
      else $error("code 0B decoded wrongly");
   AST_SEL_10X: assert property (sel_wr && reg_wdata[4:0] == 5'h0D |-> ##[1:3] pos_channel == 3'h3 && neg_channel == 3'h2 && gain_select == ACR_GAIN_10X)
      else $error("code 0D decoded wrongly");
   AST_SEL_UNITY: assert property (sel_wr && reg_wdata[4:0] == 5'h1D |-> ##[1:3] pos_channel == 3'h5 && neg_channel == 3'h2 && gain_select == ACR_GAIN_1X)
      else $error("code 1D decoded wrongly");
   AST_REF_SEL: assert property (sel_wr && reg_wdata[7:6] == 2'h1 |-> ##[1:3] reference_select_out == 2'h1)
      else $error("reference select not applied while idle");
   AST_IRQ_ACK: assert property (irq_ack |-> ##[1:2] !irq_req)
      else $error("interrupt request stays after vector");
   AST_IRQ_GIE: assert property (reg_wr && reg_addr == ACR_OFF_CPU_STATUS && !reg_wdata[7] |-> ##3 !irq_req)
      else $error("interrupt request with global enable off");

   cover property (irq_req);
   cover property ($fell(conv_powered));
   cover property (reg_rd && reg_addr == ACR_OFF_RESULT_HIGH);
endmodule : acr_top_chk

// File: test/acr_top_bench.sv
// self-checking bench for the converter control block
module acr_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import acr_pkg::*;
   logic       ref_clk   = 1'b0;
   logic       rst       = 1'b1;
   logic [2:0] reg_addr  = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr    = 1'b0;
   logic       reg_rd    = 1'b0;
   logic       irq_ack   = 1'b0;
   logic [9:0] level     = 10'h000;
   logic [7:0] reg_rdata;
   logic       irq_req;
   logic       conv_powered;
   logic [2:0] pos_channel;
   logic [2:0] neg_channel;
   logic [1:0] gain_select;
   logic [1:0] reference_select_out;
   logic [9:0] analog_value;
   logic [7:0] rv;
   int         miscompares = 0;
   int         n_checks    = 0;
   int         cyc         = 0;
   int         n;

   always #5 ref_clk = ~ref_clk;

   acr_top u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_ack(irq_ack),
      .irq_req(irq_req), .analog_value(analog_value), .conv_powered(conv_powered),
      .pos_channel(pos_channel), .neg_channel(neg_channel), .gain_select(gain_select),
      .reference_select_out(reference_select_out));
   acr_front_model u_front (.conv_powered(conv_powered), .level(level),
      .analog_value(analog_value));

   task automatic wrap_up;
      if (miscompares == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up

   // the whole run needs about 800 cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         wrap_up();
      end
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      n_checks++;
      if (got < lo || got > hi) begin
         miscompares++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : chk_rng

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   task automatic wait_idle(input int t0, output int len);
      rd(3'h1, rv);
      for (int i = 0; i < 200 && rv[6]; i++) begin
         rd(3'h1, rv);
      end
      len = cyc - t0;
   endtask : wait_idle

   task automatic conv(input logic [7:0] ctl, output int len);
      int t0;
      t0 = cyc;
      wr(3'h1, ctl);
      wait_idle(t0, len);
   endtask : conv

   task automatic wait_flag;
      rd(3'h1, rv);
      for (int i = 0; i < 100 && !rv[4]; i++) begin
         rd(3'h1, rv);
      end
      chk("flag", 8'h01, {7'h00, rv[4]});
   endtask : wait_flag

   task automatic result(input logic [7:0] lo, input logic [7:0] hi);
      rd(3'h2, rv);
      chk("result low", lo, rv);
      rd(3'h3, rv);
      chk("result high", hi, rv);
   endtask : result

   task automatic t_reset;
      for (int i = 0; i < 8; i++) begin
         rd(3'(i), rv);
         chk("reset read", 8'h00, rv);
      end
      wr(3'h4, 8'h10);
      rd(3'h4, rv);
      chk("high speed", 8'h10, rv);
      wr(3'h4, 8'h00);
   endtask : t_reset

   task automatic t_table;
      logic [7:0] code [6] = '{8'h06, 8'h08, 8'h0B, 8'h0D, 8'h5D, 8'h1F};
      logic [7:0] exp  [6] = '{8'hC0, 8'h01, 8'h22, 8'h69, 8'hA8, 8'h00};
      logic [7:0] msk  [6] = '{8'hE3, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03};
      for (int i = 0; i < 6; i++) begin
         wr(3'h0, code[i]);
         repeat (3) @(posedge ref_clk);
         chk("select", exp[i], {pos_channel, neg_channel, gain_select} & msk[i]);
         chk("reference", {6'h00, code[i][7:6]}, {6'h00, reference_select_out});
      end
   endtask : t_table

   task automatic t_first;
      level <= 10'h2A9;
      wr(3'h0, 8'h03);
      conv(8'hC0, n);
      chk_rng("first length", 50, 64, n);
      rd(3'h1, rv);
      chk("ctrl", 8'h90, rv);
      result(8'hA9, 8'h02);
      wr(3'h0, 8'h23);
      result(8'h40, 8'hAA);
   endtask : t_first

   task automatic t_second;
      int t0;
      wr(3'h1, 8'h90);
      rd(3'h1, rv);
      chk("flag cleared", 8'h80, rv);
      level <= 10'h155;
      t0 = cyc;
      wr(3'h1, 8'hC0);
      wr(3'h0, 8'h45);
      wr(3'h1, 8'h80);
      chk("held select", 8'h03, {5'h00, pos_channel});
      chk("held reference", 8'h00, {6'h00, reference_select_out});
      rd(3'h1, rv);
      chk("busy", 8'h01, {7'h00, rv[6]});
      wait_idle(t0, n);
      chk_rng("normal length", 26, 40, n);
      repeat (2) @(posedge ref_clk);
      chk("new select", 8'h05, {5'h00, pos_channel});
      chk("new reference", 8'h01, {6'h00, reference_select_out});
      result(8'h55, 8'h01);
   endtask : t_second

   task automatic t_lock;
      wr(3'h1, 8'h90);
      rd(3'h2, rv);
      level <= 10'h3C3;
      conv(8'hC0, n);
      rd(3'h3, rv);
      chk("locked high", 8'h01, rv);
      rd(3'h1, rv);
      chk("flag under lock", 8'h01, {7'h00, rv[4]});
      conv(8'hD0, n);
      result(8'hC3, 8'h03);
   endtask : t_lock

   task automatic t_irq;
      wr(3'h5, 8'h80);
      wr(3'h1, 8'h88);
      repeat (3) @(posedge ref_clk);
      chk("irq raised", 8'h01, {7'h00, irq_req});
      irq_ack <= 1'b1;
      @(posedge ref_clk);
      irq_ack <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk("irq after vector", 8'h00, {7'h00, irq_req});
      rd(3'h1, rv);
      chk("ctrl after vector", 8'h88, rv);
      wr(3'h5, 8'h00);
      conv(8'hC8, n);
      chk("irq masked", 8'h00, {7'h00, irq_req});
   endtask : t_irq

   task automatic t_free;
      wr(3'h1, 8'hF0);
      wait_flag();
      wr(3'h1, 8'hB0);
      wait_flag();
      wr(3'h1, 8'h90);
      repeat (80) @(posedge ref_clk);
      wr(3'h1, 8'h90);
      repeat (80) @(posedge ref_clk);
      rd(3'h1, rv);
      chk("free run ended", 8'h80, rv);
   endtask : t_free

   task automatic t_div;
      wr(3'h1, 8'h90);
      conv(8'hC1, n);
      chk_rng("divide 2", 26, 40, n);
      wr(3'h1, 8'h90);
      conv(8'hC3, n);
      chk_rng("divide 8", 104, 124, n);
   endtask : t_div

   task automatic t_abort;
      wr(3'h1, 8'h90);
      wr(3'h1, 8'hC0);
      repeat (6) @(posedge ref_clk);
      wr(3'h1, 8'h00);
      repeat (2) @(posedge ref_clk);
      chk("powered", 8'h00, {7'h00, conv_powered});
      rd(3'h1, rv);
      chk("aborted", 8'h00, rv);
      wr(3'h1, 8'h80);
      conv(8'hC0, n);
      chk_rng("first after abort", 50, 64, n);
   endtask : t_abort

   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_table();
      t_first();
      t_second();
      t_lock();
      t_irq();
      t_free();
      t_div();
      t_abort();
      wrap_up();
   end
endmodule : acr_top_bench

bind acr_top acr_top_chk u_chk (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .irq_ack(irq_ack),
   .irq_req(irq_req), .conv_powered(conv_powered), .pos_channel(pos_channel),
   .neg_channel(neg_channel), .gain_select(gain_select),
   .reference_select_out(reference_select_out));
